// file: logic/vtp_video_timing.sv
// Video timing registers, sync delay line and test pattern generator
`timescale 1ns/1ps
// Contract
// - Active line length from low/high registers
// - Vertical size used only by pattern
// - Delay syncs by programmed pixel clocks
// - Programmed delay adds to ten-clock pipeline
// - Hsync width from 10-bit value
// - Vsync width in lines, 10-bit value
// - Back porch clocks after hsync end
// - Vertical back porch lines in pattern
// - Horizontal front porch clocks in pattern
// - Vertical front porch lines in pattern
// - Enable bit selects generated test pattern
// - Sync widths, porch used only in pattern
// - Syncs active low by default, selectable
module vtp_video_timing (
    // Clock, reset, enable
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    // Register port
    input wire logic [7:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [7:0] rd_data,
    // Incoming video, syncs active high
    input vtp_pkg::vtp_vid_t vin,
    // Panel video
    output vtp_pkg::vtp_vid_t vout
);
    localparam int DEPTH = 1 << vtp_pkg::VTP_MEM_AW;

    vtp_pkg::vtp_state_t st;
    vtp_pkg::vtp_state_t nx;
    vtp_pkg::vtp_vid_t dl_mem [0:DEPTH-1];
    vtp_pkg::vtp_vid_t dl_rd;
    vtp_pkg::vtp_vid_t pass;
    vtp_pkg::vtp_vid_t gen;
    vtp_pkg::vtp_vid_t src;
    logic [vtp_pkg::VTP_MEM_AW-1:0] off;
    logic [vtp_pkg::VTP_MEM_AW-1:0] rd_ptr;
    logic [11:0] hlen;
    logic [11:0] vlen;
    logic hlast;
    logic vlast;

    if (DEPTH <= 4095 + 10)
    begin : g_depth_chk
        $error("Delay line too shallow for a 12-bit sync delay");
    end

    function automatic vtp_pkg::vtp_phase_t rot(input vtp_pkg::vtp_phase_t p);
        rot = vtp_pkg::vtp_phase_t'({p[2:0], p[3]});
    endfunction

    assign rd_data = st.rdata;
    assign vout = st.vout;

    // Delay line holds every pixel so data stays aligned with delayed syncs
    always_ff @(posedge clk)
    begin
        if (ce)
        begin
            dl_mem[st.wr_ptr] <= vin;
        end
    end

    // Read slot one short of the total because the output flop adds one
    assign off = vtp_pkg::VTP_MEM_AW'(st.sdelay + vtp_pkg::VTP_PIPE_LAT - 12'h001);
    assign rd_ptr = st.wr_ptr - off;
    assign dl_rd = dl_mem[rd_ptr];

    always_comb
    begin
        case (st.h)
            vtp_pkg::VTP_P_SYNC: hlen = {2'h0, st.hsw};
            vtp_pkg::VTP_P_BACK: hlen = {4'h0, st.hbp};
            vtp_pkg::VTP_P_ACT: hlen = st.line_len;
            vtp_pkg::VTP_P_FRONT: hlen = {4'h0, st.hfp};
            default: hlen = 12'h001;
        endcase
        case (st.v)
            vtp_pkg::VTP_P_SYNC: vlen = {2'h0, st.vsw};
            vtp_pkg::VTP_P_BACK: vlen = {4'h0, st.vbp};
            vtp_pkg::VTP_P_ACT: vlen = st.vsize;
            vtp_pkg::VTP_P_FRONT: vlen = {4'h0, st.vfp};
            default: vlen = 12'h001;
        endcase
        // A zero count still lasts one step so the generator never stalls
        hlast = (hlen == 12'h000) || (st.hcnt == hlen - 12'h001);
        vlast = (vlen == 12'h000) || (st.vcnt == vlen - 12'h001);
    end

    always_comb
    begin
        nx = st;
        nx.rdata = 8'h00;
        if (wr_en)
        begin
            case (addr)
                vtp_pkg::VTP_A_POL:
                begin
                    nx.hs_low = wr_data[vtp_pkg::VTP_HS_LOW_BIT];
                    nx.vs_low = wr_data[vtp_pkg::VTP_VS_LOW_BIT];
                end
                vtp_pkg::VTP_A_LL_LO: nx.line_len[7:0] = wr_data;
                vtp_pkg::VTP_A_LL_HI: nx.line_len[11:8] = wr_data[3:0];
                vtp_pkg::VTP_A_VS_LO: nx.vsize[7:0] = wr_data;
                vtp_pkg::VTP_A_VS_HI: nx.vsize[11:8] = wr_data[3:0];
                vtp_pkg::VTP_A_SD_LO: nx.sdelay[7:0] = wr_data;
                vtp_pkg::VTP_A_SD_HI: nx.sdelay[11:8] = wr_data[3:0];
                vtp_pkg::VTP_A_HW_LO: nx.hsw[7:0] = wr_data;
                vtp_pkg::VTP_A_HW_HI: nx.hsw[9:8] = wr_data[1:0];
                vtp_pkg::VTP_A_VW_LO: nx.vsw[7:0] = wr_data;
                vtp_pkg::VTP_A_VW_HI: nx.vsw[9:8] = wr_data[1:0];
                vtp_pkg::VTP_A_HBP: nx.hbp = wr_data;
                vtp_pkg::VTP_A_VBP: nx.vbp = wr_data;
                vtp_pkg::VTP_A_HFP: nx.hfp = wr_data;
                vtp_pkg::VTP_A_VFP: nx.vfp = wr_data;
                vtp_pkg::VTP_A_TP: nx.tp_en = wr_data[vtp_pkg::VTP_TP_EN_BIT];
                default: nx.rdata = 8'h00;
            endcase
        end
        if (rd_en)
        begin
            case (addr)
                vtp_pkg::VTP_A_POL: nx.rdata = {1'b0, st.hs_low, st.vs_low, 5'h00};
                vtp_pkg::VTP_A_LL_LO: nx.rdata = st.line_len[7:0];
                vtp_pkg::VTP_A_LL_HI: nx.rdata = {4'h0, st.line_len[11:8]};
                vtp_pkg::VTP_A_VS_LO: nx.rdata = st.vsize[7:0];
                vtp_pkg::VTP_A_VS_HI: nx.rdata = {4'h0, st.vsize[11:8]};
                vtp_pkg::VTP_A_SD_LO: nx.rdata = st.sdelay[7:0];
                vtp_pkg::VTP_A_SD_HI: nx.rdata = {4'h0, st.sdelay[11:8]};
                vtp_pkg::VTP_A_HW_LO: nx.rdata = st.hsw[7:0];
                vtp_pkg::VTP_A_HW_HI: nx.rdata = {6'h00, st.hsw[9:8]};
                vtp_pkg::VTP_A_VW_LO: nx.rdata = st.vsw[7:0];
                vtp_pkg::VTP_A_VW_HI: nx.rdata = {6'h00, st.vsw[9:8]};
                vtp_pkg::VTP_A_HBP: nx.rdata = st.hbp;
                vtp_pkg::VTP_A_VBP: nx.rdata = st.vbp;
                vtp_pkg::VTP_A_HFP: nx.rdata = st.hfp;
                vtp_pkg::VTP_A_VFP: nx.rdata = st.vfp;
                vtp_pkg::VTP_A_TP: nx.rdata = {3'h0, st.tp_en, 4'h0};
                default: nx.rdata = 8'h00;
            endcase
        end

        // Delay line pointer and fill level; unfilled slots read as idle
        nx.wr_ptr = st.wr_ptr + 1'b1;
        if (st.fcnt != {vtp_pkg::VTP_MEM_AW{1'b1}})
        begin
            nx.fcnt = st.fcnt + 1'b1;
        end
        pass = (st.fcnt >= off) ? dl_rd : '0;
        // Line length trims the delayed enable; pixels beyond it keep their data but lose the enable
        nx.pcnt = pass.de ? ((st.pcnt == 12'hfff) ? st.pcnt : st.pcnt + 12'h001) : 12'h000;
        pass.de = pass.de && (st.pcnt < st.line_len);

        // Pattern raster; leaving pattern mode parks it at frame start
        if (!st.tp_en)
        begin
            nx.h = vtp_pkg::VTP_P_SYNC;
            nx.v = vtp_pkg::VTP_P_SYNC;
            nx.hcnt = 12'h000;
            nx.vcnt = 12'h000;
        end
        else if (hlast)
        begin
            nx.hcnt = 12'h000;
            nx.h = rot(st.h);
            if (st.h == vtp_pkg::VTP_P_FRONT)
            begin
                if (vlast)
                begin
                    nx.vcnt = 12'h000;
                    nx.v = rot(st.v);
                end
                else
                begin
                    nx.vcnt = st.vcnt + 12'h001;
                end
            end
        end
        else
        begin
            nx.hcnt = st.hcnt + 12'h001;
        end

        gen.hs = (st.h == vtp_pkg::VTP_P_SYNC);
        gen.vs = (st.v == vtp_pkg::VTP_P_SYNC);
        gen.de = (st.h == vtp_pkg::VTP_P_ACT) && (st.v == vtp_pkg::VTP_P_ACT);
        // Colour ramps from raster position; content is free-form
        gen.pix = gen.de ? {st.hcnt[7:0], st.vcnt[7:0], st.hcnt[7:0] ^ st.vcnt[7:0]} : '0;

        src = st.tp_en ? gen : pass;
        nx.tp_out = st.tp_en;
        nx.vout = src;
        nx.vout.hs = src.hs ^ st.hs_low;
        nx.vout.vs = src.vs ^ st.vs_low;
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st <= '0;
            st.h <= vtp_pkg::VTP_P_SYNC;
            st.v <= vtp_pkg::VTP_P_SYNC;
            st.hs_low <= vtp_pkg::VTP_HS_LOW_RST;
            st.vs_low <= vtp_pkg::VTP_VS_LOW_RST;
        end
        else if (ce)
        begin
            st <= nx;
        end
    end

    // Checking helper: cycles of steady pass-through operation
    logic [5:0] qcnt;
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            qcnt <= 6'h00;
        end
        else if (!ce || wr_en || st.tp_en)
        begin
            qcnt <= 6'h00;
        end
        else if (qcnt != 6'h3f)
        begin
            qcnt <= qcnt + 6'h01;
        end
    end

    a_line_len_trim: assert property (@(posedge clk) disable iff (!rst_b)
        $past(ce) && !st.tp_out && st.vout.de |-> $past(st.pcnt) < $past(st.line_len))
        else $error("Enable passed beyond line length");

    a_pipe_latency: assert property (@(posedge clk) disable iff (!rst_b)
        qcnt >= 6'h2c && st.sdelay == 12'h020 && st.fcnt > 13'h0040
        |-> (st.vout.hs ^ st.hs_low) == $past(vin.hs, 42))
        else $error("Hsync latency not delay plus ten clocks");

    a_sync_delay: assert property (@(posedge clk) disable iff (!rst_b)
        qcnt >= 6'h2c && st.sdelay == 12'h020 && st.fcnt > 13'h0040
        |-> (st.vout.vs ^ st.vs_low) == $past(vin.vs, 42))
        else $error("Vsync not delayed by programmed amount");

    a_hsync_width: assert property (@(posedge clk) disable iff (!rst_b)
        ce && !wr_en && st.tp_en && st.h == vtp_pkg::VTP_P_SYNC && st.hsw != 10'h000
        |=> st.h == (($past(st.hcnt) + 12'h001 == {2'h0, $past(st.hsw)})
            ? vtp_pkg::VTP_P_BACK : vtp_pkg::VTP_P_SYNC))
        else $error("Hsync width wrong");

    a_hback_porch: assert property (@(posedge clk) disable iff (!rst_b)
        ce && !wr_en && st.tp_en && st.h == vtp_pkg::VTP_P_BACK && st.hbp != 8'h00
        |=> st.h == (($past(st.hcnt) + 12'h001 == {4'h0, $past(st.hbp)})
            ? vtp_pkg::VTP_P_ACT : vtp_pkg::VTP_P_BACK))
        else $error("Horizontal back porch wrong");

    a_hfront_porch: assert property (@(posedge clk) disable iff (!rst_b)
        ce && !wr_en && st.tp_en && st.h == vtp_pkg::VTP_P_FRONT && st.hfp != 8'h00
        |=> st.h == (($past(st.hcnt) + 12'h001 == {4'h0, $past(st.hfp)})
            ? vtp_pkg::VTP_P_SYNC : vtp_pkg::VTP_P_FRONT))
        else $error("Horizontal front porch wrong");

    a_vsync_width: assert property (@(posedge clk) disable iff (!rst_b)
        ce && !wr_en && st.tp_en && hlast && st.h == vtp_pkg::VTP_P_FRONT
        && st.v == vtp_pkg::VTP_P_SYNC && st.vsw != 10'h000
        |=> st.v == (($past(st.vcnt) + 12'h001 == {2'h0, $past(st.vsw)})
            ? vtp_pkg::VTP_P_BACK : vtp_pkg::VTP_P_SYNC))
        else $error("Vsync width wrong");

    a_vback_porch: assert property (@(posedge clk) disable iff (!rst_b)
        ce && !wr_en && st.tp_en && hlast && st.h == vtp_pkg::VTP_P_FRONT
        && st.v == vtp_pkg::VTP_P_BACK && st.vbp != 8'h00
        |=> st.v == (($past(st.vcnt) + 12'h001 == {4'h0, $past(st.vbp)})
            ? vtp_pkg::VTP_P_ACT : vtp_pkg::VTP_P_BACK))
        else $error("Vertical back porch wrong");

    a_vactive_size: assert property (@(posedge clk) disable iff (!rst_b)
        ce && !wr_en && st.tp_en && hlast && st.h == vtp_pkg::VTP_P_FRONT
        && st.v == vtp_pkg::VTP_P_ACT && st.vsize != 12'h000
        |=> st.v == (($past(st.vcnt) + 12'h001 == $past(st.vsize))
            ? vtp_pkg::VTP_P_FRONT : vtp_pkg::VTP_P_ACT))
        else $error("Vertical display size wrong");

    a_vfront_porch: assert property (@(posedge clk) disable iff (!rst_b)
        ce && !wr_en && st.tp_en && hlast && st.h == vtp_pkg::VTP_P_FRONT
        && st.v == vtp_pkg::VTP_P_FRONT && st.vfp != 8'h00
        |=> st.v == (($past(st.vcnt) + 12'h001 == {4'h0, $past(st.vfp)})
            ? vtp_pkg::VTP_P_SYNC : vtp_pkg::VTP_P_FRONT))
        else $error("Vertical front porch wrong");

    a_phase_order: assert property (@(posedge clk) disable iff (!rst_b)
        $changed(st.h) && st.tp_en && $past(st.tp_en) |-> st.h == rot($past(st.h)))
        else $error("Line phase out of order");

    a_pattern_idle: assert property (@(posedge clk) disable iff (!rst_b)
        ce && !st.tp_en |=> st.h == vtp_pkg::VTP_P_SYNC && st.hcnt == 12'h000)
        else $error("Pattern raster running while disabled");

    a_pattern_select: assert property (@(posedge clk) disable iff (!rst_b)
        ce && !wr_en && $rose(st.tp_en) |=> st.tp_out && st.vout.vs == !st.vs_low)
        else $error("Pattern not on output after enable");

    a_pattern_de: assert property (@(posedge clk) disable iff (!rst_b)
        ce && st.tp_en |=> st.vout.de == ($past(st.h) == vtp_pkg::VTP_P_ACT
            && $past(st.v) == vtp_pkg::VTP_P_ACT))
        else $error("Pattern enable outside active area");

    a_sync_polarity: assert property (@(posedge clk) disable iff (!rst_b)
        ce && st.tp_en && !wr_en |=> st.vout.hs
            == (($past(st.h) == vtp_pkg::VTP_P_SYNC) ^ $past(st.hs_low)))
        else $error("Hsync polarity wrong");

    a_line_len_write: assert property (@(posedge clk) disable iff (!rst_b)
        ce && wr_en && addr == vtp_pkg::VTP_A_LL_LO
        |=> st.line_len[7:0] == $past(wr_data))
        else $error("Line length low byte not written");

    a_line_len_read: assert property (@(posedge clk) disable iff (!rst_b)
        ce && rd_en && addr == vtp_pkg::VTP_A_LL_HI
        |=> rd_data == {4'h0, $past(st.line_len[11:8])})
        else $error("Line length high nibble read wrong");

    a_vsize_write: assert property (@(posedge clk) disable iff (!rst_b)
        ce && wr_en && addr == vtp_pkg::VTP_A_VS_HI
        |=> st.vsize[11:8] == $past(wr_data[3:0]))
        else $error("Vertical size high nibble not written");

    a_delay_write: assert property (@(posedge clk) disable iff (!rst_b)
        ce && wr_en && addr == vtp_pkg::VTP_A_SD_HI
        |=> st.sdelay[11:8] == $past(wr_data[3:0]))
        else $error("Sync delay high nibble not written");

    a_hold_disabled: assert property (@(posedge clk) disable iff (!rst_b)
        !ce |=> $stable(st.vout) && $stable(st.wr_ptr) && $stable(rd_data))
        else $error("State moved while clock enable low");

    a_hsync_hi_write: assert property (@(posedge clk) disable iff (!rst_b)
        ce && wr_en && addr == vtp_pkg::VTP_A_HW_HI
        |=> st.hsw[9:8] == $past(wr_data[1:0]))
        else $error("Hsync width high bits not written");

    a_vsync_lo_write: assert property (@(posedge clk) disable iff (!rst_b)
        ce && wr_en && addr == vtp_pkg::VTP_A_VW_LO
        |=> st.vsw[7:0] == $past(wr_data))
        else $error("Vsync width low byte not written");

    a_hbp_write: assert property (@(posedge clk) disable iff (!rst_b)
        ce && wr_en && addr == vtp_pkg::VTP_A_HBP |=> st.hbp == $past(wr_data))
        else $error("Horizontal back porch not written");

    a_vfp_write: assert property (@(posedge clk) disable iff (!rst_b)
        ce && wr_en && addr == vtp_pkg::VTP_A_VFP |=> st.vfp == $past(wr_data))
        else $error("Vertical front porch not written");

    a_pattern_write: assert property (@(posedge clk) disable iff (!rst_b)
        ce && wr_en && addr == vtp_pkg::VTP_A_TP
        |=> st.tp_en == $past(wr_data[vtp_pkg::VTP_TP_EN_BIT]))
        else $error("Pattern enable not written");

    a_pattern_read: assert property (@(posedge clk) disable iff (!rst_b)
        ce && rd_en && addr == vtp_pkg::VTP_A_TP
        |=> rd_data == {3'h0, $past(st.tp_en), 4'h0})
        else $error("Pattern enable read wrong");

    a_pass_source: assert property (@(posedge clk) disable iff (!rst_b)
        ce && !st.tp_en |=> !st.tp_out)
        else $error("Pattern on output while disabled");

    a_polarity_write: assert property (@(posedge clk) disable iff (!rst_b)
        ce && wr_en && addr == vtp_pkg::VTP_A_POL
        |=> st.hs_low == $past(wr_data[vtp_pkg::VTP_HS_LOW_BIT])
            && st.vs_low == $past(wr_data[vtp_pkg::VTP_VS_LOW_BIT]))
        else $error("Polarity selects not written");

    a_polarity_read: assert property (@(posedge clk) disable iff (!rst_b)
        ce && rd_en && addr == vtp_pkg::VTP_A_POL
        |=> rd_data[vtp_pkg::VTP_HS_LOW_BIT] == $past(st.hs_low)
            && rd_data[vtp_pkg::VTP_VS_LOW_BIT] == $past(st.vs_low))
        else $error("Polarity selects read wrong");
endmodule

// file: pkg/vtp_pkg.sv
// Register map, field layout, timing and state types of the video timing block
package vtp_pkg;
    // Register byte offsets
    localparam logic [7:0] VTP_A_POL = 8'h18;
    localparam logic [7:0] VTP_A_LL_LO = 8'h20;
    localparam logic [7:0] VTP_A_LL_HI = 8'h21;
    localparam logic [7:0] VTP_A_VS_LO = 8'h24;
    localparam logic [7:0] VTP_A_VS_HI = 8'h25;
    localparam logic [7:0] VTP_A_SD_LO = 8'h28;
    localparam logic [7:0] VTP_A_SD_HI = 8'h29;
    localparam logic [7:0] VTP_A_HW_LO = 8'h2c;
    localparam logic [7:0] VTP_A_HW_HI = 8'h2d;
    localparam logic [7:0] VTP_A_VW_LO = 8'h30;
    localparam logic [7:0] VTP_A_VW_HI = 8'h31;
    localparam logic [7:0] VTP_A_HBP = 8'h34;
    localparam logic [7:0] VTP_A_VBP = 8'h36;
    localparam logic [7:0] VTP_A_HFP = 8'h38;
    localparam logic [7:0] VTP_A_VFP = 8'h3a;
    localparam logic [7:0] VTP_A_TP = 8'h3c;
    // Field positions
    localparam int VTP_HS_LOW_BIT = 6;
    localparam int VTP_VS_LOW_BIT = 5;
    localparam int VTP_TP_EN_BIT = 4;
    // Reset values
    localparam logic VTP_HS_LOW_RST = 1'b1;
    localparam logic VTP_VS_LOW_RST = 1'b1;
    // Timing counts in pixel clocks
    localparam logic [11:0] VTP_PIPE_LAT = 12'h00a;
    localparam logic [11:0] VTP_MIN_SYNC_DELAY = 12'h020;
    // Delay line address width; depth must exceed 4095 plus pipeline
    localparam int VTP_MEM_AW = 13;
    localparam int VTP_PIX_W = 24;

    typedef enum logic [3:0] {
        VTP_P_SYNC = 4'h1,
        VTP_P_BACK = 4'h2,
        VTP_P_ACT = 4'h4,
        VTP_P_FRONT = 4'h8
    } vtp_phase_t;

    typedef struct packed {
        logic hs;
        logic vs;
        logic de;
        logic [VTP_PIX_W-1:0] pix;
    } vtp_vid_t;

    typedef struct packed {
        logic [11:0] line_len;
        logic [11:0] vsize;
        logic [11:0] sdelay;
        logic [9:0] hsw;
        logic [9:0] vsw;
        logic [7:0] hbp;
        logic [7:0] vbp;
        logic [7:0] hfp;
        logic [7:0] vfp;
        logic tp_en;
        logic hs_low;
        logic vs_low;
        vtp_phase_t h;
        vtp_phase_t v;
        logic [11:0] hcnt;
        logic [11:0] vcnt;
        logic [11:0] pcnt;
        logic [VTP_MEM_AW-1:0] wr_ptr;
        logic [VTP_MEM_AW-1:0] fcnt;
        logic tp_out;
        vtp_vid_t vout;
        logic [7:0] rdata;
    } vtp_state_t;
endpackage

// file: tb/vtp_src_model.sv
// Video source model streaming lines of sync, porch and pixels
`timescale 1ns/1ps
module vtp_src_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Stream into the block, syncs active high
    output vtp_pkg::vtp_vid_t vin
);
    logic [3:0] h;
    logic [1:0] v;
    logic [23:0] px;
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            h <= 4'h0;
            v <= 2'h0;
            px <= 24'h000000;
        end
        else
        begin
            h <= h + 4'h1;
            px <= px + 24'h000101;
            if (h == 4'hf)
                v <= v + 2'h1;
        end
    end
    // Pixels keep moving outside the active span, so stale data never looks valid
    always_comb
    begin
        vin.hs = h < 4'h3;
        vin.vs = v == 2'h0;
        vin.de = h >= 4'h5 && h < 4'hd;
        vin.pix = px;
    end
endmodule

// file: tb/video_timing_test_pattern_bench.sv
// Self-checking bench for the video timing and test pattern block
`timescale 1ns/1ps
module video_timing_test_pattern_bench;
    logic clk;
    logic rst_b;
    logic ce;
    logic [7:0] addr;
    logic [7:0] wr_data;
    logic wr_en;
    logic rd_en;
    logic [7:0] rd_data;
    vtp_pkg::vtp_vid_t vin;
    vtp_pkg::vtp_vid_t vout;
    vtp_pkg::vtp_vid_t hist[$];
    vtp_pkg::vtp_vid_t e;
    logic [2:0] cap[$];
    int err_total = 0;
    int n_compared = 0;
    int lat = 42;
    int ll = 0;
    int run = 0;
    logic chk_on = 1'b0;
    logic hs_low = 1'b1;
    logic vs_low = 1'b1;
    // Address, reset value, readback after writing all ones
    localparam logic [23:0] REGS [17] = '{24'h18_60_60, 24'h20_00_ff, 24'h21_00_0f,
        24'h24_00_ff, 24'h25_00_0f, 24'h28_00_ff, 24'h29_00_0f, 24'h2c_00_ff,
        24'h2d_00_03, 24'h30_00_ff, 24'h31_00_03, 24'h34_00_ff, 24'h36_00_ff,
        24'h38_00_ff, 24'h3a_00_ff, 24'h3c_00_10, 24'h22_00_00};
    // Pattern raster: 10 clocks a line, 7 lines a frame
    localparam logic [15:0] PAT [14] = '{16'h2c_03, 16'h2d_00, 16'h34_02, 16'h20_04,
        16'h21_00, 16'h38_01, 16'h30_02, 16'h31_00, 16'h36_01, 16'h24_03, 16'h25_00,
        16'h3a_01, 16'h18_60, 16'h3c_10};
    // Sync delay, line length, polarity byte
    localparam logic [31:0] PT [3] = '{32'h020_105_60, 32'h020_004_00, 32'h120_008_40};

    vtp_src_model src_u (.clk(clk), .rst_b(rst_b), .vin(vin));
    vtp_video_timing dut_u (.clk(clk), .rst_b(rst_b), .ce(ce), .addr(addr),
        .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
        .vin(vin), .vout(vout));

    task automatic check(input logic [26:0] g, input logic [26:0] x);
        n_compared++;
        if (g !== x)
        begin
            err_total++;
            $display("mismatch at %0t got %h expected %h", $time, g, x);
        end
    endtask

    task automatic summarize();
        if (err_total == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        d = rd_data;
        @(posedge clk);
    endtask

    function automatic logic [2:0] exp_pat(input int i);
        int h;
        int v;
        h = i % 10;
        v = (i / 10) % 7;
        exp_pat = {h >= 3, v >= 2, h >= 5 && h < 9 && v >= 3 && v < 6};
    endfunction

    // Reference stream: input sampled on enabled edges, trimmed and polarised
    always @(posedge clk)
    begin
        if (rst_b && ce)
        begin
            run = vin.de ? run + 1 : 0;
            e = vin;
            e.hs = vin.hs ^ hs_low;
            e.vs = vin.vs ^ vs_low;
            e.de = vin.de && (run <= ll);
            hist.push_front(e);
            if (hist.size() > 400)
                void'(hist.pop_back());
            if (chk_on)
                check(vout, hist[lat]);
        end
    end

    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // Watchdog well above the planned run
    initial
    begin
        #1000000;
        err_total++;
        summarize();
    end

    initial
    begin
        logic [7:0] got;
        logic [31:0] row;
        int s;
        rst_b = 1'b0;
        ce = 1'b1;
        addr = 8'h00;
        wr_data = 8'h00;
        wr_en = 1'b0;
        rd_en = 1'b0;
        repeat (2) @(posedge clk);
        #1;
        check(27'(rd_data), 27'h0);
        check(vout, 27'h0);
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        foreach (REGS[i])
        begin
            rd(REGS[i][23:16], got);
            check(27'(got), 27'(REGS[i][15:8]));
            wr(REGS[i][23:16], 8'hff);
            rd(REGS[i][23:16], got);
            check(27'(got), 27'(REGS[i][7:0]));
        end
        wr(8'h3c, 8'h00);
        foreach (PAT[i])
            wr(PAT[i][15:8], PAT[i][7:0]);
        repeat (200)
        begin
            @(posedge clk);
            #1;
            cap.push_back({vout.hs, vout.vs, vout.de});
        end
        // Frame start: both syncs active right after an idle vertical line
        s = -1;
        for (int i = 20; i < 100; i++)
            if (s < 0 && cap[i-1][1] && cap[i][2:1] == 2'b00)
                s = i;
        if (s < 0)
        begin
            err_total++;
            summarize();
        end
        else
            for (int i = 0; i < 100; i++)
                check(27'(cap[s+i]), 27'(exp_pat(i)));
        wr(8'h3c, 8'h00);
        foreach (PT[i])
        begin
            row = PT[i];
            chk_on <= 1'b0;
            wr(8'h28, row[27:20]);
            wr(8'h29, {4'h0, row[31:28]});
            wr(8'h20, row[15:8]);
            wr(8'h21, {4'h0, row[19:16]});
            wr(8'h18, row[7:0]);
            lat <= int'(row[31:20]) + 10;
            ll <= int'(row[19:8]);
            hs_low <= row[6];
            vs_low <= row[5];
            // Delay line must refill beyond the longest latency before comparing
            repeat (400) @(posedge clk);
            chk_on <= 1'b1;
            repeat (100) @(posedge clk);
            ce <= 1'b0;
            repeat (4) @(posedge clk);
            ce <= 1'b1;
            repeat (100) @(posedge clk);
            chk_on <= 1'b0;
        end
        rst_b <= 1'b0;
        @(posedge clk);
        #1;
        check(27'(rd_data), 27'h0);
        check(vout, 27'h0);
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        rd(8'h18, got);
        check(27'(got), 27'h60);
        rd(8'h3c, got);
        check(27'(got), 27'h0);
        summarize();
    end
endmodule
